/* File: rtl/reset_sequencer.v */
// Summary of operation
// RULE_01: Source holds reset low four half periods.
// RULE_02: Sequence starts 4 to 16 after low.
// RULE_03: Sequence lasts 1024, device pulls pin low.
// RULE_04: Condition ends 4 to 6 after rise.
// RULE_05: Source holds config 1 to 6 after rise.
// RULE_06: First address strobe 8 after end.
// RULE_07: Bus released on low, driven after end.
// RULE_08: Power-up reset low at least 1500 ns.
// RULE_09: Config bits loaded continuously during reset.
// RULE_10: Asynchronous reset enters default state immediately.
// RULE_11: Config pull-ups enabled during reset.
// RULE_12: Power-up reset held until clock stable.
// RULE_13: Fetch starts at address zero.
// RULE_14: Reset output held until end-of-init.
// RULE_15: Warm end only if pin high after sequence.
// RULE_16: Half-period counters, synchronised pin edges.
`timescale 1ns/1ps
`default_nettype none
`include "reset_seq_defs.vh"

module reset_sequencer (
    input wire CLK_SYS,
    input wire RST_B,
    input wire RESET_INPUT_N_IN,
    output wire RESET_INPUT_N_OUT,
    output wire RESET_INPUT_N_OE,
    input wire [15:0] STARTUP_CONFIG_PORT,
    output wire CFG_PULLUP_EN,
    output reg EMULATION_CFG_BIT,
    output reg CFG_BIT_A,
    output reg [2:0] CLOCK_CFG,
    output wire INTERNAL_RESET,
    output wire BUS_DRIVE_EN,
    output reg ALE,
    output reg FETCH_START,
    output reg [23:0] FETCH_ADDR,
    input wire END_OF_INIT_INSTRUCTION,
    output reg RESET_OUTPUT_N
);

localparam ST_RUN = 3'd0;
localparam ST_WAIT_SEQ = 3'd1;
localparam ST_SEQ = 3'd2;
localparam ST_WAIT_HIGH = 3'd3;
localparam ST_END_DLY = 3'd4;
localparam ST_ALE_DLY = 3'd5;

reg [2:0] state_reg;
reg [2:0] state_next;
reg [`CNT_W-1:0] cnt_reg;
reg [`CNT_W-1:0] cnt_next;
wire pin_level;
wire pin_fall;
wire pin_rise;

function cnt_done;
    input [`CNT_W-1:0] c;
    input integer lim;
    begin
        cnt_done = (c == lim - 1);
    end
endfunction

////////////////////////////////////////////////////////////////////////
// Pin synchroniser and edge detect
reset_in_sync u_sync (
    .clk(CLK_SYS),
    .rst_b(RST_B),
    .pin_in(RESET_INPUT_N_IN),
    .level_reg(pin_level),
    .fall_reg(pin_fall),
    .rise_reg(pin_rise)
); // [RULE_16]

////////////////////////////////////////////////////////////////////////
// Sequence state machine
always @*
begin
    state_next = state_reg;
    cnt_next = cnt_reg + 1'b1;
    case (state_reg)
        ST_RUN:
        begin
            // A fall counts only once it has passed the synchroniser
            if (pin_fall)
            begin
                state_next = ST_WAIT_SEQ;
                cnt_next = {`CNT_W{1'b0}};
            end
        end
        ST_ALE_DLY:
        begin
            if (cnt_done(cnt_reg, `ALE_DELAY_HCP))
                state_next = ST_RUN;
            // A new fall before the strobe restarts the whole sequence
            if (pin_fall)
            begin
                state_next = ST_WAIT_SEQ;
                cnt_next = {`CNT_W{1'b0}};
            end
        end
        ST_WAIT_SEQ:
        begin
            // Sync latency counts toward the start window
            if (cnt_done(cnt_reg, `SEQ_START_HCP - 3)) // [RULE_02]
            begin
                state_next = ST_SEQ;
                cnt_next = {`CNT_W{1'b0}};
            end
        end
        ST_SEQ:
        begin
            // Pin falls here come from our own pull-down and are ignored
            if (cnt_done(cnt_reg, `SEQ_LEN_HCP)) // [RULE_03]
            begin
                state_next = ST_WAIT_HIGH;
                cnt_next = {`CNT_W{1'b0}};
            end
        end
        ST_WAIT_HIGH:
        begin
            // Own pull-down is off now; a pin still low keeps the part in reset
            cnt_next = {`CNT_W{1'b0}};
            if (pin_level) // [RULE_15]
                state_next = ST_END_DLY;
        end
        ST_END_DLY:
        begin
            // Configuration capture keeps running through this delay
            if (cnt_done(cnt_reg, `COND_END_HCP - 3)) // [RULE_04]
            begin
                state_next = ST_ALE_DLY;
                cnt_next = {`CNT_W{1'b0}};
            end
        end
        default:
        begin
            state_next = ST_RUN;
            cnt_next = {`CNT_W{1'b0}};
        end
    endcase
end

// Default state is entered without the clock
always @(posedge CLK_SYS or negedge RST_B)
begin
    if (!RST_B) // [RULE_10]
    begin
        state_reg <= ST_WAIT_HIGH;
        cnt_reg <= {`CNT_W{1'b0}};
    end
    else
    begin
        state_reg <= state_next;
        cnt_reg <= cnt_next;
    end
end

////////////////////////////////////////////////////////////////////////
// Pin, pull-up and bus control
// The own pull-down is on only in the counted sequence, not in the waits
wire in_reset = (state_reg == ST_WAIT_SEQ) || (state_reg == ST_SEQ) ||
                (state_reg == ST_WAIT_HIGH) || (state_reg == ST_END_DLY);

assign INTERNAL_RESET = in_reset;
assign RESET_INPUT_N_OUT = 1'b0;
assign RESET_INPUT_N_OE = (state_reg == ST_SEQ); // [RULE_03]
assign CFG_PULLUP_EN = in_reset; // [RULE_11]
// Release is combinational on the held state; a pin fall costs sync latency
assign BUS_DRIVE_EN = !in_reset; // [RULE_07]

////////////////////////////////////////////////////////////////////////
// Start-up configuration capture; open lines read one, hence the reset value
always @(posedge CLK_SYS or negedge RST_B)
begin
    if (!RST_B)
    begin
        EMULATION_CFG_BIT <= 1'b1;
        CFG_BIT_A <= 1'b1;
        CLOCK_CFG <= 3'h7;
    end
    else if (in_reset) // [RULE_09]
    begin
        EMULATION_CFG_BIT <= STARTUP_CONFIG_PORT[`CFG_EMU_BIT];
        CFG_BIT_A <= STARTUP_CONFIG_PORT[`CFG_CFG_BIT_A_BIT];
        CLOCK_CFG <= STARTUP_CONFIG_PORT[`CFG_CLK_MSB:`CFG_CLK_LSB];
    end
end

////////////////////////////////////////////////////////////////////////
// First address strobe and fetch start after the condition ends
always @(posedge CLK_SYS or negedge RST_B)
begin
    if (!RST_B)
    begin
        ALE <= 1'b0;
        FETCH_START <= 1'b0;
        FETCH_ADDR <= `START_ADDR;
    end
    else
    begin
        ALE <= (state_reg == ST_ALE_DLY) && cnt_done(cnt_reg, `ALE_DELAY_HCP); // [RULE_06]
        FETCH_START <= (state_reg == ST_END_DLY) && (state_next == ST_ALE_DLY);
        // No boot vector option: fetch always begins at zero
        FETCH_ADDR <= `START_ADDR; // [RULE_13]
    end
end

////////////////////////////////////////////////////////////////////////
// Reset output; only software ends it, any new reset pulls it low again
always @(posedge CLK_SYS or negedge RST_B)
begin
    if (!RST_B)
        RESET_OUTPUT_N <= 1'b0;
    else if (in_reset)
        RESET_OUTPUT_N <= 1'b0;
    else if (END_OF_INIT_INSTRUCTION) // [RULE_14]
        RESET_OUTPUT_N <= 1'b1;
end

endmodule // reset_sequencer

`default_nettype wire

/* File: rtl/reset_seq_defs.vh */
`ifndef RESET_SEQ_DEFS_VH
`define RESET_SEQ_DEFS_VH

// Timing in half clock periods; one half clock period is one CLK_SYS cycle here
`define HCP_NS 8
`define SEQ_START_MIN_HCP 4
`define SEQ_START_MAX_HCP 16
`define SEQ_START_HCP 5
`define SEQ_LEN_HCP 1024
`define COND_END_MIN_HCP 4
`define COND_END_MAX_HCP 6
`define COND_END_HCP 5
`define ALE_DELAY_HCP 8
`define CNT_W 11
// Configuration port fields
`define CFG_EMU_BIT 0
`define CFG_CFG_BIT_A_BIT 1
`define CFG_CLK_LSB 13
`define CFG_CLK_MSB 15
`define START_ADDR 24'h00_0000

`endif

/* File: rtl/reset_in_sync.v */
`timescale 1ns/1ps
`default_nettype none

module reset_in_sync (
    input wire clk,
    input wire rst_b,
    input wire pin_in,
    output reg level_reg,
    output reg fall_reg,
    output reg rise_reg
);

reg meta_reg;
reg sync_reg;

// Two-stage synchroniser; only the second stage feeds the edge detect
always @(posedge clk or negedge rst_b)
begin
    if (!rst_b)
    begin
        meta_reg <= 1'b0;
        sync_reg <= 1'b0;
        level_reg <= 1'b0;
        fall_reg <= 1'b0;
        rise_reg <= 1'b0;
    end
    else
    begin
        meta_reg <= pin_in;
        sync_reg <= meta_reg;
        level_reg <= sync_reg;
        fall_reg <= level_reg & ~sync_reg;
        rise_reg <= ~level_reg & sync_reg;
    end
end

endmodule // reset_in_sync

`default_nettype wire

/* File: dv/reset_source_model.sv */
`timescale 1ns/1ps
`default_nettype none
module reset_source_model (
    input wire logic hold_low,
    input wire logic [15:0] pd_mask,
    input wire logic pin_oe,
    input wire logic pin_out,
    output logic pin,
    output logic [15:0] port
);
    // Wired-AND with a pull-up: a released pin reads high, never the old value
    assign pin = !(hold_low || (pin_oe && !pin_out));
    // Open lines read one, tied lines zero; held stable past the rise
    assign port = ~pd_mask;
endmodule // reset_source_model
`default_nettype wire

/* File: dv/reset_sequencer_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module reset_sequencer_checker (
    input wire logic CLK_SYS,
    input wire logic RST_B,
    input wire logic RESET_INPUT_N_IN,
    input wire logic RESET_INPUT_N_OE,
    input wire logic [15:0] STARTUP_CONFIG_PORT,
    input wire logic EMULATION_CFG_BIT,
    input wire logic CFG_BIT_A,
    input wire logic [2:0] CLOCK_CFG,
    input wire logic INTERNAL_RESET,
    input wire logic BUS_DRIVE_EN,
    input wire logic ALE
);
    logic [10:0] oe_len;
    wire [4:0] cfg = {CLOCK_CFG, CFG_BIT_A, EMULATION_CFG_BIT};
    wire [4:0] pcfg = {STARTUP_CONFIG_PORT[15:13], STARTUP_CONFIG_PORT[1:0]};
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_B);
    // 1024 is too long to unroll, so count it
    always @(posedge CLK_SYS or negedge RST_B)
        if (!RST_B)
            oe_len <= 11'h000;
        else
            oe_len <= RESET_INPUT_N_OE ? oe_len + 11'h001 : 11'h000;
    a_seq_start: assert property ($fell(RESET_INPUT_N_IN) && !INTERNAL_RESET
        |-> !RESET_INPUT_N_OE[*4] ##[1:13] RESET_INPUT_N_OE) else $error("bad start");
    a_seq_len: assert property ($fell(RESET_INPUT_N_OE) |-> oe_len == 11'h400) else $error("bad length");
    a_cond_end: assert property ($rose(RESET_INPUT_N_IN) && INTERNAL_RESET && !RESET_INPUT_N_OE
        |-> INTERNAL_RESET[*4] ##[1:3] !INTERNAL_RESET) else $error("bad end");
    a_ale_first: assert property ($fell(INTERNAL_RESET) |-> !ALE[*8] ##1 ALE) else $error("bad strobe");
    a_bus_release: assert property ($fell(RESET_INPUT_N_IN) |-> ##[0:6] !BUS_DRIVE_EN) else $error("late release");
    a_bus_drive: assert property (BUS_DRIVE_EN == !INTERNAL_RESET) else $error("bad drive");
    a_cfg_load: assert property (INTERNAL_RESET |=> cfg == $past(pcfg)) else $error("cfg not loaded");
    a_cfg_hold: assert property (!INTERNAL_RESET |=> $stable(cfg)) else $error("cfg moved");
    cover property ($fell(RESET_INPUT_N_OE));
    cover property (ALE);
    cover property ($fell(INTERNAL_RESET));
endmodule // reset_sequencer_checker
bind reset_sequencer reset_sequencer_checker chk_u (.CLK_SYS, .RST_B, .RESET_INPUT_N_IN, .RESET_INPUT_N_OE,
    .STARTUP_CONFIG_PORT, .EMULATION_CFG_BIT, .CFG_BIT_A, .CLOCK_CFG, .INTERNAL_RESET, .BUS_DRIVE_EN, .ALE);
`default_nettype wire

/* File: dv/tb_reset_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_reset_sequencer;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic hold_low = 1'b0;
    logic eoi = 1'b0;
    logic [15:0] pd_mask = 16'h0000;
    wire pin, oe, pout, pull_en, emulation_cfg_bit, cfga, ir, bus_en, ale, fstart, rout;
    wire [15:0] port;
    wire [2:0] ccfg;
    wire [23:0] faddr;
    int bad_count = 0;
    int num_checks = 0;
    reset_sequencer dut_u (.CLK_SYS(clk_sys), .RST_B(rst_b), .RESET_INPUT_N_IN(pin), .RESET_INPUT_N_OUT(pout),
        .RESET_INPUT_N_OE(oe), .STARTUP_CONFIG_PORT(port), .CFG_PULLUP_EN(pull_en), .EMULATION_CFG_BIT(emulation_cfg_bit),
        .CFG_BIT_A(cfga), .CLOCK_CFG(ccfg), .INTERNAL_RESET(ir), .BUS_DRIVE_EN(bus_en), .ALE(ale),
        .FETCH_START(fstart), .FETCH_ADDR(faddr), .END_OF_INIT_INSTRUCTION(eoi), .RESET_OUTPUT_N(rout));
    reset_source_model src_u (.hold_low(hold_low), .pd_mask(pd_mask), .pin_oe(oe), .pin_out(pout),
        .pin(pin), .port(port));
    initial
        forever #4 clk_sys = ~clk_sys;
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD %0t got %0h want %0h", $time, seen, exp);
        end
    endtask
    task step;
        @(posedge clk_sys);
        #1;
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Tail shared by both resets; called once the pin reads high
    task end_seq(input logic [15:0] pd, input int lo, input int hi);
        int k;
        k = 0;
        while (ir !== 1'b0 && k < 20)
        begin
            step;
            k++;
        end
        chk(k >= lo && k <= hi, 1);
        chk({ccfg, cfga, emulation_cfg_bit}, {~pd[15:13], ~pd[1:0]});
        chk({bus_en, fstart, faddr, rout}, 27'h600_0000);
        k = 0;
        while (ale !== 1'b1 && k < 20)
        begin
            step;
            k++;
        end
        chk(k, 8);
        @(posedge clk_sys);
        eoi <= 1'b1;
        @(posedge clk_sys);
        eoi <= 1'b0;
        #1;
        chk(rout, 1'b1);
    endtask
    task t_power_up;
        @(posedge clk_sys);
        #1;
        chk({ir, pull_en, oe, bus_en, rout, ale, ccfg, cfga, emulation_cfg_bit}, 11'h61f);
        repeat (4) @(posedge clk_sys);
        rst_b <= 1'b1;
        #1;
        end_seq(16'h0000, 1, 19);
        $display("power-up done");
    endtask
    // A long hold keeps the pin low past the sequence, so the end must wait
    task t_warm(input int hold, input logic [15:0] pd);
        int n;
        @(posedge clk_sys);
        hold_low <= 1'b1;
        pd_mask <= pd;
        fork
            begin
                repeat (hold) @(posedge clk_sys);
                hold_low <= 1'b0;
            end
        join_none
        n = 0;
        while (oe !== 1'b1 && n < 20)
        begin
            step;
            n++;
        end
        chk(n >= 4 && n <= 16, 1);
        n = 0;
        while (oe === 1'b1 && n < 1100)
        begin
            step;
            n++;
        end
        chk(n, 1024);
        n = 0;
        while (pin !== 1'b1 && n < 2000)
        begin
            step;
            n++;
        end
        chk(ir, 1'b1);
        end_seq(pd, 4, 6);
        $display("warm done");
    endtask
    // Power-up reset dropped into a running sequence; no clock edge may be needed to see it
    task t_async(input logic [15:0] pd);
        @(posedge clk_sys);
        hold_low <= 1'b1;
        pd_mask <= pd;
        repeat (20) @(posedge clk_sys);
        rst_b <= 1'b0;
        hold_low <= 1'b0;
        #1;
        chk({ir, pull_en, oe, bus_en, rout, ale, ccfg, cfga, emulation_cfg_bit}, 11'h61f);
        repeat (190) @(posedge clk_sys);
        rst_b <= 1'b1;
        #1;
        end_seq(pd, 1, 19);
        $display("async done");
    endtask
    initial
    begin
        t_power_up;
        t_warm(6, 16'ha001);
        t_async(16'h6001);
        t_warm(1100, 16'h4002);
        complete_run;
    end
    initial
    begin
        #40000;
        bad_count++;
        complete_run;
    end
endmodule // tb_reset_sequencer
`default_nettype wire
